// ### rtl/rx_lpi_pkg.sv
package rx_lpi_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned LINK_QUAL_TIME_S = 1;
    localparam int unsigned LINK_QUAL_CYCLES = LINK_QUAL_TIME_S * CLK_HZ;
    localparam int unsigned US_TIME          = 1;
    localparam int unsigned US_CYCLES        = (CLK_HZ / 1_000_000) * US_TIME;

    // Consecutive receive clocks needed to accept a change
    localparam logic [2:0] LPI_ON_SAMPLES  = 3'h3;
    localparam logic [2:0] LPI_OFF_SAMPLES = 3'h4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFS_TRANS  = 8'h10;
    localparam logic [7:0] OFS_TIME   = 8'h14;

    // Control bit positions
    localparam int unsigned CTRL_EEE_BIT    = 0;
    localparam int unsigned CTRL_RXON_BIT   = 1;
    localparam int unsigned CTRL_WAKE_BIT   = 2;
    localparam int unsigned CTRL_REMOTE_BIT = 3;

    // Event bit positions in status, clear and enable
    localparam int unsigned EV_START  = 0;
    localparam int unsigned EV_WAKE   = 1;
    localparam int unsigned EV_ENERGY = 2;

    // Values after reset
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [2:0]  EVENT_RESET  = 3'h0;
    localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;

    // Link speed codes
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    typedef enum logic [1:0] {
        F_OFF  = 2'h0,
        F_RISE = 2'h1,
        F_ON   = 2'h3,
        F_FALL = 2'h2
    } filt_state_e;

endpackage

// ### rtl/pin_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync2 #(
    parameter int unsigned W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule

`default_nettype wire

// ### rtl/lpi_glitch_filter.sv
`timescale 1ns/100ps
`default_nettype none

module lpi_glitch_filter
    import rx_lpi_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sample_i,
    input  wire logic lpi_i,
    output logic      valid_o
);

    filt_state_e state_reg;
    filt_state_e state_next;
    logic [2:0]  cnt_reg;
    logic [2:0]  cnt_next;
    logic [2:0]  cnt_inc;

    assign cnt_inc = cnt_reg + 3'h1;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            F_OFF: begin
                if (lpi_i) begin
                    state_next = F_RISE;
                    cnt_next   = 3'h1;
                end
            end
            F_RISE: begin
                if (!lpi_i) begin
                    state_next = F_OFF;
                end else if (cnt_inc == LPI_ON_SAMPLES) begin
                    state_next = F_ON;
                end else begin
                    cnt_next = cnt_inc;
                end
            end
            F_ON: begin
                if (!lpi_i) begin
                    state_next = F_FALL;
                    cnt_next   = 3'h1;
                end
            end
            F_FALL: begin
                if (lpi_i) begin
                    state_next = F_ON;
                end else if (cnt_inc == LPI_OFF_SAMPLES) begin
                    state_next = F_OFF;
                end else begin
                    cnt_next = cnt_inc;
                end
            end
        endcase
    end

    // Moves only on a receive clock sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= F_OFF;
            cnt_reg   <= 3'h0;
        end else if (sample_i) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign valid_o = (state_reg == F_ON) || (state_reg == F_FALL);

    a_rise_three: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(valid_o) |-> $past(state_reg) == F_RISE
            && $past(cnt_reg) == LPI_ON_SAMPLES - 3'h1 && $past(lpi_i))
        else $error("Idle accepted before three active samples");

    a_fall_four: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(valid_o) |-> $past(state_reg) == F_FALL
            && $past(cnt_reg) == LPI_OFF_SAMPLES - 3'h1 && !$past(lpi_i))
        else $error("Idle dropped before four inactive samples");

endmodule

`default_nettype wire

// ### rtl/eee_rx_lpi_detector.sv
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Idle valid after 3 on, 4 off
// - Idle start sets flag; enable gates interrupt
// - Idle end sets wake flag if enabled
// - Wake flag sets status; enable gates remote wake
// - Power state never blocks or forces wake
// - Decode only with enable, speed, duplex, negotiation
// - Link up one second before decoding
// - Receiver enable does not stop decoding
// - Count idle rising transitions, read only
// - Count idle microseconds, read only
// - Counters run in every power state

module eee_rx_lpi_detector
    import rx_lpi_pkg::*;
#(
    parameter int unsigned QUAL_CYCLES = LINK_QUAL_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        rxc_i,
    input  wire logic        rx_lpi_i,
    input  wire logic        link_up_i,
    input  wire logic [1:0]  speed_i,
    input  wire logic        full_duplex_i,
    input  wire logic        an_eee_ok_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             remote_wake_o
);

    // Pin sampling; the RGMII clock is slow enough to find edges
    logic [1:0]  pins_sync;
    logic        rxc_prev_reg;
    logic        rxc_rise;
    logic        sample;
    logic        lpi_valid;

    pin_sync2 #(
        .W (2)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({rxc_i, rx_lpi_i}),
        .q_o   (pins_sync)
    );

    assign rxc_rise = pins_sync[1] && !rxc_prev_reg;
    assign sample   = rxc_rise && ce_i;

    // A stopped receive clock simply holds the filter where it was
    lpi_glitch_filter u_filter (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (sample),
        .lpi_i    (pins_sync[0]),
        .valid_o  (lpi_valid)
    );

    // Control and state registers
    logic [3:0]  ctrl_reg;
    logic [3:0]  ctrl_next;
    logic [2:0]  irq_en_reg;
    logic [2:0]  irq_en_next;
    logic [2:0]  flags_reg;
    logic [2:0]  flags_next;
    logic        lpi_prev_reg;
    logic [31:0] qual_cnt_reg;
    logic [31:0] qual_cnt_next;
    logic [6:0]  us_cnt_reg;
    logic [31:0] trans_cnt_reg;
    logic [31:0] time_cnt_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;

    // Link qualification
    wire eee_on     = ctrl_reg[CTRL_EEE_BIT];
    wire wake_en    = ctrl_reg[CTRL_WAKE_BIT];
    wire remote_en  = ctrl_reg[CTRL_REMOTE_BIT];
    wire speed_ok   = (speed_i == SPEED_100) || (speed_i == SPEED_1000);
    wire cond_ok    = eee_on && speed_ok && full_duplex_i
                      && an_eee_ok_i && link_up_i;
    wire qual_done  = (qual_cnt_reg == QUAL_CYCLES);
    // Receiver enable stays out of this term on purpose
    wire decode_ok  = cond_ok && qual_done;

    assign qual_cnt_next = !cond_ok ? 32'h0000_0000 :
                           qual_done ? qual_cnt_reg :
                           qual_cnt_reg + 32'h0000_0001;

    // Events from the filtered indication
    wire lpi_rise   = lpi_valid && !lpi_prev_reg;
    wire lpi_fall   = !lpi_valid && lpi_prev_reg;
    wire start_ev   = decode_ok && lpi_rise;
    wire wake_ev    = decode_ok && lpi_fall && wake_en;
    wire us_tick    = (us_cnt_reg == 7'(US_CYCLES - 1));

    // Bus decode
    wire req        = wb_cyc_i && wb_stb_i;
    wire wr_take    = req && wb_we_i && ack_reg;
    wire lane0      = wb_sel_i[0];
    wire hit_ctrl   = (wb_adr_i == OFS_CTRL);
    wire hit_stat   = (wb_adr_i == OFS_STATUS);
    wire hit_clear  = (wb_adr_i == OFS_CLEAR);
    wire hit_irq_en = (wb_adr_i == OFS_IRQ_EN);
    wire hit_trans  = (wb_adr_i == OFS_TRANS);
    wire hit_time   = (wb_adr_i == OFS_TIME);
    wire wr_ctrl    = wr_take && hit_ctrl && lane0;
    wire wr_irq_en  = wr_take && hit_irq_en && lane0;
    wire wr_clear   = wr_take && hit_clear && lane0;

    wire [2:0] clr_bits = wr_clear ? wb_dat_i[2:0] : EVENT_RESET;
    // A wake flag cleared in this cycle no longer re-sets the status
    wire       wake_kept  = flags_reg[EV_WAKE] && !clr_bits[EV_WAKE];
    wire       energy_set = wake_kept || wake_ev;
    wire [2:0] set_bits = {energy_set, wake_ev, start_ev};

    // Set wins over a clear in the same cycle
    assign flags_next  = (flags_reg & ~clr_bits) | set_bits;
    assign ctrl_next   = wr_ctrl ? wb_dat_i[3:0] : ctrl_reg;
    assign irq_en_next = wr_irq_en ? wb_dat_i[2:0] : irq_en_reg;

    wire [31:0] status_word = {26'h000_0000, decode_ok, lpi_valid,
                               1'b0, flags_reg};

    // Counters are read only; unmapped and write-only words read zero
    assign dat_next = hit_ctrl   ? {28'h000_0000, ctrl_reg} :
                      hit_stat   ? status_word :
                      hit_irq_en ? {29'h0000_0000, irq_en_reg} :
                      hit_trans  ? trans_cnt_reg :
                      hit_time   ? time_cnt_reg :
                      32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxc_prev_reg <= 1'b0;
            lpi_prev_reg <= 1'b0;
            qual_cnt_reg <= COUNT_RESET;
            us_cnt_reg   <= 7'h00;
        end else if (ce_i) begin
            rxc_prev_reg <= pins_sync[1];
            lpi_prev_reg <= lpi_valid;
            qual_cnt_reg <= qual_cnt_next;
            us_cnt_reg   <= us_tick ? 7'h00 : us_cnt_reg + 7'h01;
        end
    end

    // No power state input: counters and wake never depend on it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trans_cnt_reg <= COUNT_RESET;
            time_cnt_reg  <= COUNT_RESET;
        end else if (ce_i) begin
            if (lpi_rise) begin
                trans_cnt_reg <= trans_cnt_reg + 32'h0000_0001;
            end
            if (us_tick && lpi_valid) begin
                time_cnt_reg <= time_cnt_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= CTRL_RESET;
            irq_en_reg <= EVENT_RESET;
            flags_reg  <= EVENT_RESET;
        end else if (ce_i) begin
            ctrl_reg   <= ctrl_next;
            irq_en_reg <= irq_en_next;
            flags_reg  <= flags_next;
        end
    end

    // One wait state: data and ack are both registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg) begin
                dat_reg <= dat_next;
            end
        end
    end

    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = dat_reg;
    assign irq_o         = |(flags_reg & irq_en_reg);
    assign remote_wake_o = flags_reg[EV_ENERGY] && remote_en;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_start_sets_flag: assert property (
        ce_i && start_ev |=> flags_reg[EV_START])
        else $error("Idle start did not set its flag");

    a_start_irq_gate: assert property (
        flags_reg[EV_START] && irq_en_reg[EV_START] |-> irq_o)
        else $error("Enabled idle start flag gives no interrupt");

    a_wake_needs_enable: assert property (
        $rose(flags_reg[EV_WAKE]) |-> $past(wake_en) && $past(lpi_fall))
        else $error("Wake flag set without enable or idle end");

    a_wake_sets_energy: assert property (
        ce_i && flags_reg[EV_WAKE] && !clr_bits[EV_WAKE]
        |=> flags_reg[EV_ENERGY])
        else $error("Wake flag did not set energy wake status");

    a_remote_gate: assert property (
        remote_wake_o |-> flags_reg[EV_ENERGY] && remote_en)
        else $error("Remote wake without status and enable");

    a_no_decode_early: assert property (
        (start_ev || wake_ev) |-> cond_ok && qual_cnt_reg == QUAL_CYCLES)
        else $error("Idle decoded before link qualified");

    a_qual_restart: assert property (
        ce_i && !link_up_i |=> qual_cnt_reg == 32'h0000_0000)
        else $error("Qualification timer kept running on link loss");

    a_trans_count: assert property (
        ce_i && lpi_rise |=> trans_cnt_reg == $past(trans_cnt_reg) + 32'h1)
        else $error("Transition counter missed an idle start");

    a_time_count: assert property (
        ce_i && us_tick && lpi_valid
        |=> time_cnt_reg == $past(time_cnt_reg) + 32'h1)
        else $error("Duration counter missed a microsecond");

    a_flag_sticky: assert property (
        ce_i && flags_reg[EV_START] && !clr_bits[EV_START]
        |=> flags_reg[EV_START])
        else $error("Idle start flag lost without a clear");

    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o || !ce_i)
        else $error("Bus ack held for two cycles");

    c_idle_start:  cover property (ce_i && start_ev);
    c_wake_flag:   cover property ($rose(flags_reg[EV_WAKE]));
    c_remote_wake: cover property ($rose(remote_wake_o));
    c_irq_raised:  cover property ($rose(irq_o));

endmodule

`default_nettype wire

// ### tb/phy_rx_model.sv
`timescale 1ns/100ps
`default_nettype none

module phy_rx_model (
    input  wire logic lpi_req_i,
    input  wire logic halt_i,
    output logic      rxc_o,
    output logic      rx_lpi_o
);
    logic ck      = 1'b0;
    logic stopped = 1'b0;
    int   n       = 0;

    initial rx_lpi_o = 1'b0;
    always #32 ck = ~ck;
    assign rxc_o = ck & ~stopped;

    // Idle changes on the falling edge so each rising edge sees it settled
    always @(negedge ck) begin
        if (stopped) begin
            stopped <= lpi_req_i;
        end else if (lpi_req_i) begin
            rx_lpi_o <= 1'b1;
            n        <= n + 1;
            stopped  <= halt_i && n >= 9;
        end else begin
            rx_lpi_o <= 1'b0;
            n        <= 0;
        end
    end
endmodule

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import rx_lpi_pkg::*;
    localparam int QUAL = 150;
    logic clk = 0, rst = 1, ce = 1, link = 1, fd = 1, an = 1, req = 0;
    logic cyc = 0, stb = 0, we = 0, halt = 0, ack, irq, rwk, rxc, lpi;
    logic [1:0]  spd = SPEED_1000;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] dw = 0, dr, rd, r, t0;
    int miscompares = 0, compares = 0, cycles = 0, exp_tr = 0;

    always #4 clk = ~clk;
    phy_rx_model phy_rx_model_i (.lpi_req_i(req), .halt_i(halt),
        .rxc_o(rxc), .rx_lpi_o(lpi));
    eee_rx_lpi_detector #(.QUAL_CYCLES(QUAL)) eee_rx_lpi_detector_i (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .rxc_i(rxc), .rx_lpi_i(lpi),
        .link_up_i(link), .speed_i(spd), .full_duplex_i(fd),
        .an_eee_ok_i(an), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .irq_o(irq), .remote_wake_o(rwk));

    task automatic check(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Holds the request until ack is sampled; an idle cycle comes first
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dw <= d; sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
        if (n >= 50) miscompares++;
        rd = dr;
        cyc <= 0; stb <= 0; we <= 0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(nm, rd, e);
    endtask

    // on_n rising edges see idle, off_n see it gone
    task automatic burst(input int on_n, input int off_n);
        @(posedge rxc);
        req <= 1;
        repeat (on_n) @(posedge rxc);
        req <= 0;
        repeat (off_n) @(posedge rxc);
    endtask

    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(52));
        repeat (2) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 7; i++)
            rchk("reset reg", i == 6 ? 8'h20 : 8'(i * 4), 32'h0);
        check("irq", irq, 1'h0);
        $display("test reset done");
        r = $urandom;
        wb(1, OFS_CTRL, {r[31:4], 4'h5});
        rchk("ctrl", OFS_CTRL, 32'h5);
        wb(1, OFS_TRANS, r);
        rchk("trans", OFS_TRANS, 32'h0);
        wb(1, OFS_TIME, r);
        rchk("time", OFS_TIME, 32'h0);
        wb(1, OFS_IRQ_EN, 32'h2);
        $display("test registers done");
        link <= 0;
        burst(2, 6);
        rchk("trans", OFS_TRANS, exp_tr);
        link <= 1;
        burst(3, 6);
        exp_tr++;
        repeat (8) @(posedge clk);
        rchk("status", OFS_STATUS, 32'h0);
        rchk("trans", OFS_TRANS, exp_tr);
        rchk("trans", OFS_TRANS, exp_tr);
        $display("test qualify done");
        wb(1, OFS_CTRL, 32'h3);
        repeat (QUAL + 20) @(posedge clk);
        rchk("status", OFS_STATUS, 32'h20);
        burst(3 + $urandom % 4, 6);
        exp_tr++;
        repeat (8) @(posedge clk);
        rchk("status", OFS_STATUS, 32'h21);
        check("irq", irq, 1'h0);
        wb(1, OFS_IRQ_EN, 32'h7);
        repeat (2) @(posedge clk);
        check("irq", irq, 1'h1);
        repeat (50) @(posedge clk);
        rchk("status", OFS_STATUS, 32'h21);
        wb(1, OFS_CLEAR, 32'h1);
        rchk("status", OFS_STATUS, 32'h20);
        check("irq", irq, 1'h0);
        $display("test start done");
        wb(1, OFS_CTRL, 32'h5);
        burst(5, 2);
        burst(4, 6);
        exp_tr++;
        repeat (8) @(posedge clk);
        rchk("status", OFS_STATUS, 32'h27);
        rchk("trans", OFS_TRANS, exp_tr);
        check("remote", rwk, 1'h0);
        wb(1, OFS_CTRL, 32'hD);
        repeat (2) @(posedge clk);
        check("remote", rwk, 1'h1);
        wb(1, OFS_CLEAR, 32'h7);
        rchk("status", OFS_STATUS, 32'h20);
        check("remote", rwk, 1'h0);
        $display("test wake done");
        for (int i = 0; i < 6; i++) begin
            spd <= i == 0 ? 2'h0 : i == 1 ? 2'h3 : SPEED_100;
            fd <= i != 2;
            an <= i != 3;
            link <= i != 4;
            wb(1, OFS_CTRL, i == 5 ? 32'h4 : 32'h5);
            repeat (QUAL + 20) @(posedge clk);
            burst(4, 6);
            exp_tr++;
            repeat (8) @(posedge clk);
            rchk("status", OFS_STATUS, 32'h0);
            rchk("trans", OFS_TRANS, exp_tr);
        end
        link <= 1;
        wb(1, OFS_CTRL, 32'h5);
        $display("test disqualify done");
        // Long halted idle: the time count is only checked to lie within 19 to 22 microseconds
        repeat (QUAL + 20) @(posedge clk);
        halt <= 1;
        wb(1'b0, OFS_TIME, 32'h0);
        t0 = rd;
        @(posedge rxc);
        req <= 1;
        repeat (2500) @(posedge clk);
        req <= 0;
        repeat (100) @(posedge clk);
        exp_tr++;
        wb(1'b0, OFS_TIME, 32'h0);
        r = rd - t0;
        check("idle us", r >= 19 && r <= 22, 1'h1);
        rchk("status", OFS_STATUS, 32'h27);
        rchk("trans", OFS_TRANS, exp_tr);
        $display("test halt done");
        finish_test();
    end
endmodule

`default_nettype wire
